// file: src/ssmc_clkdiv.v
// ssmc_clkdiv.v - serial clock phase generator
// assumes half_period is at least 1 and held steady while run is high
`timescale 1ns/100ps
`default_nettype none

module ssmc_clkdiv (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // control
   input wire run,
   input wire use_ext,
   input wire ext_tick,
   input wire [15:0] half_period,
   // result
   output wire phase_o,
   output wire edge_o
);

   reg [15:0] cnt_q;
   reg phase_q;
   wire half_done;

   // external tick source gives one toggle per tick (rate halved)
   assign half_done = use_ext ? ext_tick : (cnt_q + 16'h0001 >= half_period);

   // phase falls back to idle whenever the clock is not running
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
         phase_q <= 1'b0;
      end else if (!run) begin
         cnt_q <= 16'h0000;
         phase_q <= 1'b0;
      end else if (half_done) begin
         cnt_q <= 16'h0000;
         phase_q <= ~phase_q;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   assign phase_o = phase_q;
   assign edge_o = run & half_done;

endmodule

`default_nettype wire

// file: src/ssmc_defines.vh
// ssmc_defines.vh - offsets, field positions, reset values and mode codes
// assumes an 8-bit register window on apb with one word per register
`ifndef SSMC_DEFINES_VH
`define SSMC_DEFINES_VH

// register byte offsets
`define SSMC_OFS_CTRL1 8'h00
`define SSMC_OFS_RELOAD 8'h04
`define SSMC_OFS_IRQ_STAT 8'h08
`define SSMC_OFS_IRQ_MASK 8'h0c
`define SSMC_OFS_PIN_STAT 8'h10

// control register one fields
`define SSMC_CTRL1_WRITE_COLLISION_FLAG 7
`define SSMC_CTRL1_OVF 6
`define SSMC_CTRL1_EN 5
`define SSMC_CTRL1_CKP 4
`define SSMC_CTRL1_MODE_HI 3
`define SSMC_CTRL1_MODE_LO 0

// reset values
`define SSMC_RST_CTRL1 8'h00
`define SSMC_RST_RELOAD 8'h00
`define SSMC_RST_IRQ 3'h0

// interrupt status bits
`define SSMC_IRQ_START 0
`define SSMC_IRQ_STOP 1
`define SSMC_IRQ_BADMODE 2

// mode codes
`define SSMC_M_SPI_M4 4'h0
`define SSMC_M_SPI_M16 4'h1
`define SSMC_M_SPI_M64 4'h2
`define SSMC_M_SPI_MTMR 4'h3
`define SSMC_M_SPI_S_SS 4'h4
`define SSMC_M_SPI_S_NOSS 4'h5
`define SSMC_M_I2C_S7 4'h6
`define SSMC_M_I2C_S10 4'h7
`define SSMC_M_I2C_M 4'h8
`define SSMC_M_RSV9 4'h9
`define SSMC_M_RSVA 4'ha
`define SSMC_M_I2C_FW 4'hb
`define SSMC_M_RSVC 4'hc
`define SSMC_M_RSVD 4'hd
`define SSMC_M_I2C_S7I 4'he
`define SSMC_M_I2C_S10I 4'hf

// half periods of the serial clock, in pclk cycles (fosc/4, /16, /64)
`define SSMC_HALF_DIV4 16'h0002
`define SSMC_HALF_DIV16 16'h0008
`define SSMC_HALF_DIV64 16'h0020

`endif

// file: src/ssmc_sync.v
// ssmc_sync.v - two flip-flop synchroniser for a group of pin levels
// assumes each bit is an independent level from outside the pclk domain
`timescale 1ns/100ps
`default_nettype none

module ssmc_sync #(
   parameter W = 4
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // levels
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

`default_nettype wire

// file: src/ssmc_top.v
// ssmc_top.v - mode control of the synchronous serial port, apb slave
// assumes the shift engine and pin mux sit outside and share pclk
// What this block does
// - i2c slave: bit clear stretches clock low, set releases it
// - i2c master: clock polarity bit has no effect
// - low mode codes are spi master; 0010 gives clock at fosc/64
// - spi slave on external clock, with or without slave select
// - i2c slave modes for 7-bit and 10-bit addresses
// - code 1011 is firmware i2c master, address logic idle
// - 1110/1111 i2c slave with start and stop interrupts
// - enable bit takes the port pins, clear returns them to gpio
`timescale 1ns/100ps
`default_nettype none
`include "ssmc_defines.vh"

module ssmc_top (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // from the shift engine and timer, same clock
   input wire xfer_active,
   input wire timer_two_tick,
   // serial pins, levels from outside
   input wire sck_i,
   output reg sck_o,
   output reg sck_oe,
   input wire ss_n_i,
   input wire sda_i,
   input wire scl_i,
   output wire scl_o,
   output reg scl_oe,
   // pin ownership selects
   output reg own_sck,
   output reg own_sdo,
   output reg own_sdi,
   output reg own_ss,
   output reg own_sda,
   output reg own_scl,
   // state towards the shift engine
   output reg slave_selected,
   output reg slave_clk_edge,
   output reg addr_ten_bit,
   output reg addr_match_en,
   // interrupt
   output wire irq
);

   // mode classification, used in several places
   function is_rsv;
      input [3:0] m;
      begin
         is_rsv = (m == `SSMC_M_RSV9) | (m == `SSMC_M_RSVA) |
            (m == `SSMC_M_RSVC) | (m == `SSMC_M_RSVD);
      end
   endfunction

   function is_i2c_slave;
      input [3:0] m;
      begin
         is_i2c_slave = (m == `SSMC_M_I2C_S7) | (m == `SSMC_M_I2C_S10) |
            (m == `SSMC_M_I2C_S7I) | (m == `SSMC_M_I2C_S10I);
      end
   endfunction

   function is_spi_master;
      input [3:0] m;
      begin
         is_spi_master = (m[3:2] == 2'b00);
      end
   endfunction

   function is_spi_slave;
      input [3:0] m;
      begin
         is_spi_slave = (m == `SSMC_M_SPI_S_SS) | (m == `SSMC_M_SPI_S_NOSS);
      end
   endfunction

   reg [7:0] ctrl1_q;
   reg [7:0] reload_q;
   reg [2:0] irq_stat_q;
   reg [2:0] irq_mask_q;
   reg [2:0] irq_stat_d;
   reg scl_prev_q;
   reg sda_prev_q;
   reg sck_prev_q;
   reg [15:0] half_period;
   reg clk_run;
   reg [31:0] rd_mux;
   reg addr_hit;
   wire [3:0] mode;
   wire port_en;
   wire clock_polarity_release;
   wire [3:0] pins_s;
   wire sck_s;
   wire ss_n_s;
   wire sda_s;
   wire scl_s;
   wire div_phase;
   wire wr_en;
   wire rd_setup;
   wire start_det;
   wire stop_det;
   wire i2c_slv;
   wire rsv_wr;

   assign mode = ctrl1_q[`SSMC_CTRL1_MODE_HI:`SSMC_CTRL1_MODE_LO];
   assign port_en = ctrl1_q[`SSMC_CTRL1_EN];
   assign clock_polarity_release = ctrl1_q[`SSMC_CTRL1_CKP];
   assign i2c_slv = port_en & is_i2c_slave(mode);

   // pins cross into pclk before anything looks at them
   ssmc_sync #(
      .W(4)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_i({sck_i, ss_n_i, sda_i, scl_i}),
      .sync_o(pins_s)
   );

   assign sck_s = pins_s[3];
   assign ss_n_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign scl_s = pins_s[0];

   // apb decode; zero wait states, unmapped offsets answer with an error
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pslverr = psel & penable & ~addr_hit;
   // reserved codes are the caller's fault, so flag them to software
   // reserved code flag
   assign rsv_wr = wr_en & (paddr == `SSMC_OFS_CTRL1) & is_rsv(pwdata[3:0]);

   always @* begin
      addr_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `SSMC_OFS_CTRL1: rd_mux = {24'h00_0000, ctrl1_q};
         `SSMC_OFS_RELOAD: rd_mux = {24'h00_0000, reload_q};
         `SSMC_OFS_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_q};
         `SSMC_OFS_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_q};
         `SSMC_OFS_PIN_STAT: rd_mux = {24'h00_0000, 2'h0, slave_selected, addr_ten_bit,
            pins_s};
         default: addr_hit = 1'b0;
      endcase
   end

   // read data captured in the setup cycle, stable through the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_q <= `SSMC_RST_CTRL1;
         reload_q <= `SSMC_RST_RELOAD;
         irq_mask_q <= `SSMC_RST_IRQ;
      end else if (wr_en) begin
         if (paddr == `SSMC_OFS_CTRL1) begin
            ctrl1_q <= pwdata[7:0];
         end
         if (paddr == `SSMC_OFS_RELOAD) begin
            reload_q <= pwdata[7:0];
         end
         if (paddr == `SSMC_OFS_IRQ_MASK) begin
            irq_mask_q <= pwdata[2:0];
         end
      end
   end

   // previous pin levels for edge detection, second stage only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_prev_q <= 1'b0;
         sda_prev_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         sck_prev_q <= sck_s;
      end
   end

   assign start_det = i2c_slv & scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det = i2c_slv & scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // sticky status, write one to clear; a new event beats the clear
   always @* begin
      irq_stat_d = irq_stat_q;
      if (wr_en && paddr == `SSMC_OFS_IRQ_STAT) begin
         irq_stat_d = irq_stat_q & ~pwdata[2:0];
      end
      if (start_det && mode[3:2] == 2'b11) begin
         irq_stat_d[`SSMC_IRQ_START] = 1'b1;
      end
      if (stop_det && mode[3:2] == 2'b11) begin
         irq_stat_d[`SSMC_IRQ_STOP] = 1'b1;
      end
      if (rsv_wr) begin
         irq_stat_d[`SSMC_IRQ_BADMODE] = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= `SSMC_RST_IRQ;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // clock rate selection for the master modes
   always @* begin
      half_period = `SSMC_HALF_DIV4;
      clk_run = 1'b0;
      case (mode)
         `SSMC_M_SPI_M4: half_period = `SSMC_HALF_DIV4;
         `SSMC_M_SPI_M16: half_period = `SSMC_HALF_DIV16;
         `SSMC_M_SPI_M64: half_period = `SSMC_HALF_DIV64;
         `SSMC_M_SPI_MTMR: half_period = `SSMC_HALF_DIV4;
         // fosc / (4 * (reload + 1))
         `SSMC_M_I2C_M: half_period = {7'h00, reload_q, 1'b0} + 16'h0002;
         default: half_period = `SSMC_HALF_DIV4;
      endcase
      // firmware master gets no automatic clock
      if (port_en && xfer_active && (is_spi_master(mode) || mode == `SSMC_M_I2C_M)) begin
         clk_run = 1'b1;
      end
   end

   ssmc_clkdiv u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(clk_run),
      .use_ext(mode == `SSMC_M_SPI_MTMR),
      .ext_tick(timer_two_tick),
      .half_period(half_period),
      .phase_o(div_phase),
      .edge_o()
   );

   // pin drive, registered so pins never glitch on decode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_o <= 1'b0;
         sck_oe <= 1'b0;
         scl_oe <= 1'b0;
      end else begin
         sck_o <= clock_polarity_release ^ div_phase;
         sck_oe <= port_en & is_spi_master(mode);
         if (!port_en) begin
            scl_oe <= 1'b0;
         end else if (is_i2c_slave(mode)) begin
            scl_oe <= ~clock_polarity_release;
         end else if (mode == `SSMC_M_I2C_M) begin
            scl_oe <= div_phase;
         end else begin
            scl_oe <= 1'b0;
         end
      end
   end

   // open drain: only ever pulls low
   assign scl_o = 1'b0;

   // pin ownership and slave state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         own_sck <= 1'b0;
         own_sdo <= 1'b0;
         own_sdi <= 1'b0;
         own_ss <= 1'b0;
         own_sda <= 1'b0;
         own_scl <= 1'b0;
         slave_selected <= 1'b0;
         slave_clk_edge <= 1'b0;
         addr_ten_bit <= 1'b0;
         addr_match_en <= 1'b0;
      end else begin
         own_sck <= port_en & (is_spi_master(mode) | is_spi_slave(mode));
         own_sdo <= port_en & (is_spi_master(mode) | is_spi_slave(mode));
         own_sdi <= port_en & (is_spi_master(mode) | is_spi_slave(mode));
         own_ss <= port_en & (mode == `SSMC_M_SPI_S_SS);
         own_sda <= port_en & (mode[3] | (mode[3:1] == 3'b011)) & ~is_rsv(mode);
         own_scl <= port_en & (mode[3] | (mode[3:1] == 3'b011)) & ~is_rsv(mode);
         slave_selected <= port_en & ((mode == `SSMC_M_SPI_S_NOSS) |
            ((mode == `SSMC_M_SPI_S_SS) & ~ss_n_s));
         slave_clk_edge <= port_en & is_spi_slave(mode) & (sck_s ^ sck_prev_q) &
            ((mode == `SSMC_M_SPI_S_NOSS) | ~ss_n_s);
         addr_ten_bit <= i2c_slv & mode[0];
         // address logic idle outside i2c slave modes
         addr_match_en <= i2c_slv;
      end
   end

endmodule

`default_nettype wire

// file: tb/ssmc_peer.sv
// ssmc_peer.sv - far-side serial peer: link clock, select, i2c lines
// assumes frame and sda_drv come from the bench, scl_oe from the port
`timescale 1ns/100ps
`default_nettype none

module ssmc_peer (
   // control from the bench
   input wire logic frame,
   input wire logic sda_drv,
   input wire logic scl_oe,
   // pins towards the port
   output var logic sck_i,
   output var logic ss_n_i,
   output logic sda_i,
   output logic scl_i
);
   int k;
   // open-drain lines rest high on their pull-ups
   assign sda_i = sda_drv;
   assign scl_i = !scl_oe;
   assign ss_n_i = !frame;
   // eight edges a frame; clock stands still outside frames
   initial begin
      sck_i = 1'b0;
      k = 0;
      #7;
      forever begin
         #80;
         if (frame && k < 8) begin
            sck_i = !sck_i;
            k++;
         end else if (!frame) begin
            k = 0;
         end
      end
   end
endmodule

`default_nettype wire

// file: tb/ssmc_top_properties.sv
// ssmc_top_properties.sv - port checker for the mode control block
// assumes control writes land at offset 0 and pready stays high
`timescale 1ns/100ps
`default_nettype none

module ssmc_top_props (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   // watched outputs
   input wire xfer_active,
   input wire sck_o,
   input wire sck_oe,
   input wire scl_oe,
   input wire own_sck,
   input wire own_sda,
   input wire own_scl,
   input wire addr_ten_bit,
   input wire addr_match_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = psel && penable && pwrite && paddr == 8'h00;
   wire [3:0] m = pwdata[3:0];
   reg [7:0] ctl_q;
   // shadow of the control byte, so mode checks need no decode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) ctl_q <= 8'h00;
      else if (wr) ctl_q <= pwdata[7:0];
   end
   property p_off;
      // pin selects follow the stored control byte one edge later
      wr && !pwdata[5] |-> ##2 !own_sck && !own_sda && !own_scl && !sck_oe;
   endproperty
   a_off: assert property (p_off) else $error("pins kept while off");
   property p_spi;
      wr && pwdata[5] && m < 4'h4 |-> ##2 own_sck && sck_oe;
   endproperty
   a_spi: assert property (p_spi) else $error("spi master pins");
   property p_idle;
      wr && pwdata[5] && m < 4'h3 && !xfer_active |-> ##2 sck_o == $past(pwdata[4], 2);
   endproperty
   a_idle: assert property (p_idle) else $error("idle clock level");
   property p_stretch;
      $past(ctl_q[5]) && $past(ctl_q[2:1]) == 2'b11 |-> scl_oe == !$past(ctl_q[4]);
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock stretch");
   property p_div64;
      sck_oe && ctl_q[3:0] == 4'h2 && xfer_active && $changed(sck_o)
         |-> ##32 ($changed(sck_o) || !xfer_active);
   endproperty
   a_div64: assert property (p_div64) else $error("clock not at /64");
   property p_ten;
      wr && pwdata[5] && m[3:1] == 3'b011 |-> ##2 addr_ten_bit == $past(pwdata[0], 2);
   endproperty
   a_ten: assert property (p_ten) else $error("address width");
   property p_fw;
      wr && pwdata[5:0] == 6'h2b |-> ##2 !addr_match_en && own_scl;
   endproperty
   a_fw: assert property (p_fw) else $error("firmware master");
   property p_rsv;
      wr && (m == 4'h9 || m == 4'ha || m == 4'hc || m == 4'hd) |-> ##2 !own_sck && !own_scl;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved mode owns pins");
endmodule

bind ssmc_top ssmc_top_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .xfer_active, .sck_o, .sck_oe, .scl_oe, .own_sck, .own_sda, .own_scl,
   .addr_ten_bit, .addr_match_en);

`default_nettype wire

// file: tb/test_ssmc_top.sv
// test_ssmc_top.sv - register-level bench for the mode control block
// assumes ssmc_peer stands on the pins and the checker is bound
`timescale 1ns/100ps
`default_nettype none

module test_ssmc_top;
   logic pclk, presetn, psel, penable, pwrite, xfer_active, timer_two_tick, frame, sda_drv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, n, e0, n_edge;
   logic pready, pslverr, err, v, sck_i, sck_o, sck_oe, ss_n_i, sda_i, scl_i, scl_o, scl_oe;
   logic own_sck, own_sdo, own_sdi, own_ss, own_sda, own_scl, irq;
   logic slave_selected, slave_clk_edge, addr_ten_bit, addr_match_en;
   int miscompares, n_checks, i;
   logic [7:0] cs [3] = '{8'h26, 8'h37, 8'h36};
   logic [3:0] rs [4] = '{4'h9, 4'ha, 4'hc, 4'hd};

   ssmc_top u_ssmc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .xfer_active, .timer_two_tick, .sck_i, .sck_o, .sck_oe, .ss_n_i,
      .sda_i, .scl_i, .scl_o, .scl_oe, .own_sck, .own_sdo, .own_sdi, .own_ss, .own_sda,
      .own_scl, .slave_selected, .slave_clk_edge, .addr_ten_bit, .addr_match_en, .irq);
   ssmc_peer u_peer (.frame, .sda_drv, .scl_oe, .sck_i, .ss_n_i, .sda_i, .scl_i);

   initial begin
      pclk = 1'b0;
      forever #10 pclk = !pclk;
   end
   // pulses are counted here so scenarios only take differences
   initial n_edge = 32'h0;
   always @(posedge pclk) if (slave_clk_edge === 1'b1) n_edge <= n_edge + 32'h1;

   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, s, x);
      end
   endtask
   task chk1(input logic s, input logic x);
      chk({31'h0, s}, {31'h0, x});
   endtask
   // one apb transfer; request held until pready seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (3) @(posedge pclk);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
   endtask
   // cycles between two changes of sck_o or scl_oe
   task half(input logic sel, output logic [31:0] c);
      v = sel ? scl_oe : sck_o;
      c = 32'h0;
      while ((sel ? scl_oe : sck_o) === v) @(posedge pclk);
      v = sel ? scl_oe : sck_o;
      while ((sel ? scl_oe : sck_o) === v) begin
         @(posedge pclk);
         c++;
      end
   endtask
   task sda_pulse;
      sda_drv <= 1'b0;
      repeat (10) @(posedge pclk);
      sda_drv <= 1'b1;
      repeat (10) @(posedge pclk);
   endtask

   initial begin
      #400000;
      miscompares++;
      finish_test;
   end

   initial begin
      {psel, penable, pwrite, xfer_active, timer_two_tick, frame} = 6'h00;
      sda_drv = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then one unmapped place; pin status shows idle lines
      for (i = 0; i < 6; i++) begin
         rc(8'(i * 4), (i == 4) ? 32'h7 : 32'h0);
         chk1(err, i == 5);
      end
      chk1(own_sck, 1'b0);
      for (i = 0; i < 2; i++) begin
         wr(8'h00, 32'h22 | (i << 4));
         chk1(sck_o, i[0]);
         chk1(own_sck, 1'b1);
         chk1(own_sdo & own_sdi, 1'b1);
      end
      for (i = 0; i < 3; i++) begin
         wr(8'h00, 32'h20 + i);
         xfer_active <= 1'b1;
         half(1'b0, n);
         chk(n, 32'h2 << (2 * i));
         xfer_active <= 1'b0;
      end
      // timer-driven rate: one toggle per tick
      wr(8'h00, 32'h23);
      xfer_active <= 1'b1;
      repeat (3) @(posedge pclk);
      v = sck_o;
      timer_two_tick <= 1'b1;
      @(posedge pclk);
      timer_two_tick <= 1'b0;
      repeat (4) @(posedge pclk);
      chk1(sck_o, !v);
      xfer_active <= 1'b0;
      wr(8'h00, 32'h24);
      e0 = n_edge;
      frame <= 1'b1;
      repeat (60) @(posedge pclk);
      chk1(slave_selected, 1'b1);
      chk(n_edge - e0, 32'h8);
      chk1(own_ss, 1'b1);
      frame <= 1'b0;
      wr(8'h00, 32'h25);
      chk1(own_ss, 1'b0);
      chk1(slave_selected, 1'b1);
      foreach (cs[j]) begin
         wr(8'h00, {24'h0, cs[j]});
         chk1(addr_ten_bit, cs[j][0]);
         chk1(scl_oe, !cs[j][4]);
         chk1(scl_o, 1'b0);
         chk1(addr_match_en, 1'b1);
      end
      wr(8'h00, 32'h2b);
      chk1(addr_match_en, 1'b0);
      chk1(own_scl, 1'b1);
      // master rate with both polarity settings
      wr(8'h04, 32'h2);
      for (i = 0; i < 2; i++) begin
         wr(8'h00, 32'h28 | (i << 4));
         xfer_active <= 1'b1;
         half(1'b1, n);
         chk(n, 32'h6);
         xfer_active <= 1'b0;
      end
      // start and stop events, mask, write-one clear
      wr(8'h0c, 32'h3);
      wr(8'h00, 32'h3e);
      sda_pulse;
      rc(8'h08, 32'h3);
      chk1(irq, 1'b1);
      wr(8'h0c, 32'h0);
      chk1(irq, 1'b0);
      wr(8'h08, 32'h3);
      rc(8'h08, 32'h0);
      wr(8'h00, 32'h36);
      sda_pulse;
      rc(8'h08, 32'h0);
      foreach (rs[j]) begin
         wr(8'h00, {28'h2, rs[j]});
         chk1(own_sck | own_scl, 1'b0);
         rc(8'h08, 32'h4);
         wr(8'h08, 32'h4);
      end
      wr(8'h00, 32'h06);
      chk1(own_sda, 1'b0);
      chk1(own_sdo | own_sdi, 1'b0);
      finish_test;
   end
endmodule

`default_nettype wire
